// ---- i2c_slv_consts.svh ----
// register map, field positions and reset values of the i2c slave address unit
// Function
// RL1: stretch mode one: interrupts only after acknowledge
// RL2: master read: address and data flags together
// RL3: master write: first data flag after acked byte
// RL4: software must choose mode one for high speed
// RL5: idle until start, then receive and compare address
// RL6: mismatching address ignored, wait for next start
// RL7: matching address sets the address hit flag
// RL8: mode zero holds clock until flag cleared
// RL9: direction bit changes only on valid address
// RL10: collision bit set when addressed packet collided
// RL11: collision releases both lines, no interrupt raised
// RL12: collision handling follows address resolution arbitration
// RL13: flag clear releases clock, transfer continues by direction
`ifndef I2C_SLV_CONSTS_SVH
`define I2C_SLV_CONSTS_SVH

// apb byte offsets
`define OFS_CTRL 12'h000
`define OFS_OWN 12'h004
`define OFS_STATUS 12'h008
`define OFS_FLAGS 12'h00c
`define OFS_MASK 12'h010
`define OFS_DATA 12'h014

// primary_control_word fields
`define CTRL_EN 0
`define CTRL_STRETCH 1

// status fields
`define ST_DIR 0
`define ST_TRANSMIT_COLLISION_BIT 1
`define ST_HOLD 2

// interrupt_flag_word and mask fields
`define FL_AHIT 0
`define FL_DRDY 1
`define FL_STOP 2
`define FL_W 3

// reset values
`define RST_OWN 7'h00
`define RST_FLAGS 3'h0
`define RST_BYTE 8'h00

// bits per byte on the wire
`define BYTE_BITS 4'h8

`endif

// ---- i2c_slv_pkg.sv ----
// types shared by the i2c slave address unit
`default_nettype none
package i2c_slv_pkg;
  // gray codes along idle, address, ack, data, data ack
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ADDR = 3'h1,
    S_AACK = 3'h3,
    S_DATA = 3'h2,
    S_DACK = 3'h6
  } st_t;
endpackage
`default_nettype wire

// ---- i2c_link_if.sv ----
// synchronised bus levels and bus events between the slave modules
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
  logic scl;      // filtered scl level
  logic sda;      // filtered sda level
  logic scl_rise; // one-cycle pulse
  logic scl_fall; // one-cycle pulse
  logic start;    // sda falls while scl high
  logic stop;     // sda rises while scl high
  modport det (input scl, input sda, output scl_rise, output scl_fall, output start,
    output stop);
  modport mon (input scl, input sda, input scl_rise, input scl_fall, input start,
    input stop);
endinterface
`default_nettype wire

// ---- i2c_pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module i2c_pin_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);
  logic s1_q; // metastable stage, read only by s2_q
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  // chain of three flops; idle bus reads high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lvl_q <= 1'b1;
    end else if (s2_q == s3_q) begin
      lvl_q <= s3_q;
    end
  end

  assign level = lvl_q;
endmodule
`default_nettype wire

// ---- i2c_cond_detect.sv ----
// edge, start and stop detection on filtered bus levels
`timescale 1ns/1ps
`default_nettype none
module i2c_cond_detect (
  input wire logic clk,
  input wire logic rst,
  i2c_link_if.det lk
);
  logic scl_q; // previous filtered scl
  logic sda_q; // previous filtered sda

  // remember last levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= lk.scl;
      sda_q <= lk.sda;
    end
  end

  assign lk.scl_rise = lk.scl & ~scl_q;
  assign lk.scl_fall = ~lk.scl & scl_q;
  // sda moving with scl high steady is a bus condition
  assign lk.start = lk.scl & scl_q & sda_q & ~lk.sda;
  assign lk.stop = lk.scl & scl_q & ~sda_q & lk.sda;
endmodule
`default_nettype wire

// ---- i2c_slave_addr.sv ----
// i2c slave address reception, clock stretching and apb register file
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slv_consts.svh"
module i2c_slave_addr (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  output logic IRQ
);
  // software-visible state
  logic en_q;                  // slave enabled
  logic mode_q;                // clock_stretch_strategy
  logic [6:0] own_q;           // own bus address
  logic dir_q;                 // 1: master reads
  logic transmit_collision_bit_q;                // transmit_collision_bit
  logic [`FL_W-1:0] flag_q;    // interrupt_flag_word
  logic [`FL_W-1:0] mask_q;    // interrupt mask
  logic [7:0] tx_q;            // byte to send on master read
  logic [7:0] rx_q;            // last byte received
  logic [31:0] prdata_q;       // read data captured in setup
  logic slverr_q;              // unmapped address seen in setup

  // bus engine state
  i2c_slv_pkg::st_t st_q;      // engine state
  logic [3:0] cnt_q;           // bits clocked in this byte
  logic [7:0] sh_q;            // shift register, both directions
  logic stretch_q;             // allowed to hold scl while flags pend
  logic nack_q;                // master answered not-acknowledge

  // synchronised link
  i2c_link_if lk ();
  logic scl_s;
  logic sda_s;

  i2c_pin_sync u_scl_sync (
    .clk(CLK),
    .rst(RST),
    .pin(SCL_I),
    .level(scl_s)
  );

  i2c_pin_sync u_sda_sync (
    .clk(CLK),
    .rst(RST),
    .pin(SDA_I),
    .level(sda_s)
  );

  assign lk.scl = scl_s;
  assign lk.sda = sda_s;

  i2c_cond_detect u_det (
    .clk(CLK),
    .rst(RST),
    .lk(lk)
  );

  // apb strobes
  logic setup;    // first cycle of a transfer
  logic wr_acc;   // write access phase, takes effect here
  logic hit;      // address decodes to a register
  logic [31:0] rd_mux;

  assign setup = PSEL & ~PENABLE;
  assign wr_acc = PSEL & PENABLE & PWRITE;

  // read mux and decode
  always_comb begin
    rd_mux = 32'h0;
    hit = 1'b1;
    if (PADDR == `OFS_CTRL) begin
      rd_mux[`CTRL_EN] = en_q;
      rd_mux[`CTRL_STRETCH] = mode_q;
    end else if (PADDR == `OFS_OWN) begin
      rd_mux[6:0] = own_q;
    end else if (PADDR == `OFS_STATUS) begin
      rd_mux[`ST_DIR] = dir_q;
      rd_mux[`ST_TRANSMIT_COLLISION_BIT] = transmit_collision_bit_q;
      rd_mux[`ST_HOLD] = SCL_OE;
    end else if (PADDR == `OFS_FLAGS) begin
      rd_mux[`FL_W-1:0] = flag_q;
    end else if (PADDR == `OFS_MASK) begin
      rd_mux[`FL_W-1:0] = mask_q;
    end else if (PADDR == `OFS_DATA) begin
      rd_mux[7:0] = rx_q;
    end else begin
      // unmapped: reads zero, error answer
      hit = 1'b0;
    end
  end

  // read data registered in setup so prdata comes from a flop;
  // costs nothing since access phase always ends in one cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      prdata_q <= 32'h0;
      slverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= PWRITE ? 32'h0 : rd_mux;
      slverr_q <= ~hit;
    end
  end

  assign PRDATA = prdata_q;
  assign PSLVERR = slverr_q;
  assign PREADY = PSEL & PENABLE;

  // control, address, mask and tx byte writes
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      en_q <= 1'b0;
      mode_q <= 1'b0;
      own_q <= `RST_OWN;
      mask_q <= `RST_FLAGS;
      tx_q <= `RST_BYTE;
    end else if (wr_acc) begin
      if (PADDR == `OFS_CTRL) begin
        en_q <= PWDATA[`CTRL_EN];
        // high speed needs mode one; software's choice, not checked
        // RL4 mode chosen here
        mode_q <= PWDATA[`CTRL_STRETCH];
      end else if (PADDR == `OFS_OWN) begin
        own_q <= PWDATA[6:0];
      end else if (PADDR == `OFS_MASK) begin
        mask_q <= PWDATA[`FL_W-1:0];
      end else if (PADDR == `OFS_DATA) begin
        tx_q <= PWDATA[7:0];
      end
    end
  end

  // bus event decode
  logic byte_done;  // eighth bit clocked and scl low again
  logic addr_ok;    // received address is ours
  logic e_match0;   // mode zero match, before ack
  logic e_match1;   // mode one match, after ack
  logic e_drdy;     // data flag event
  logic e_transmit_collision_bit;     // we released sda but it read low
  logic e_stop;     // stop ends our transfer
  logic hold_busy;  // flags that keep the clock held
  logic [`FL_W-1:0] fl_set;
  logic [`FL_W-1:0] fl_clr;

  assign byte_done = (cnt_q == `BYTE_BITS) & lk.scl_fall;
  assign addr_ok = (sh_q[7:1] == own_q);
  assign e_match0 = (st_q == i2c_slv_pkg::S_ADDR) & byte_done & addr_ok & ~mode_q;
  assign e_match1 = (st_q == i2c_slv_pkg::S_AACK) & lk.scl_fall & mode_q;
  // master read in mode one: data flag joins the address flag;
  // later data flags come after every acknowledged byte
  assign e_drdy = (e_match1 & dir_q) |
    ((st_q == i2c_slv_pkg::S_DACK) & lk.scl_fall & ~(dir_q & nack_q));
  assign e_transmit_collision_bit = (st_q == i2c_slv_pkg::S_DATA) & dir_q & lk.scl_rise & sh_q[7] & ~lk.sda;
  assign e_stop = lk.stop & (st_q != i2c_slv_pkg::S_IDLE);
  assign hold_busy = flag_q[`FL_AHIT] | flag_q[`FL_DRDY];

  // RL7 address hit sets flag
  assign fl_set = {e_stop, e_drdy, e_match0 | e_match1};
  assign fl_clr = (wr_acc && PADDR == `OFS_FLAGS) ? PWDATA[`FL_W-1:0] : `RST_FLAGS;

  // sticky flags; write one clears, a same-cycle event wins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      flag_q <= `RST_FLAGS;
    end else begin
      flag_q <= (flag_q & ~fl_clr) | fl_set;
    end
  end

  // one level interrupt from unmasked flags
  assign IRQ = |(flag_q & mask_q);

  // direction and collision status
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dir_q <= 1'b0;
      transmit_collision_bit_q <= 1'b0;
    end else begin
      // RL9 direction only on valid address
      if ((st_q == i2c_slv_pkg::S_ADDR) && byte_done && addr_ok) begin
        dir_q <= sh_q[0];
      end
      // RL10 collision sticks until written one
      if (e_transmit_collision_bit) begin
        transmit_collision_bit_q <= 1'b1;
      end else if (wr_acc && PADDR == `OFS_STATUS && PWDATA[`ST_TRANSMIT_COLLISION_BIT]) begin
        transmit_collision_bit_q <= 1'b0;
      end
    end
  end

  // bus engine
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_q <= i2c_slv_pkg::S_IDLE;
      cnt_q <= 4'h0;
      sh_q <= `RST_BYTE;
      stretch_q <= 1'b0;
      nack_q <= 1'b0;
      rx_q <= `RST_BYTE;
    end else if (!en_q || lk.stop) begin
      // disabled or stop: back to idle, end stretch, release lines
      st_q <= i2c_slv_pkg::S_IDLE;
      stretch_q <= 1'b0;
    end else if (lk.start) begin
      // RL5 start, repeated or not, begins address
      st_q <= i2c_slv_pkg::S_ADDR;
      cnt_q <= 4'h0;
      stretch_q <= 1'b0;
    end else begin
      // RL13 cleared flags release the clock
      if (stretch_q && !hold_busy) begin
        stretch_q <= 1'b0;
      end
      // reload tx byte while held, so late data writes still count
      if (stretch_q && dir_q && st_q == i2c_slv_pkg::S_DATA) begin
        sh_q <= tx_q;
      end
      case (st_q)
        i2c_slv_pkg::S_IDLE: begin
          cnt_q <= 4'h0;
        end
        i2c_slv_pkg::S_ADDR: begin
          if (lk.scl_rise) begin
            sh_q <= {sh_q[6:0], lk.sda};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            if (addr_ok) begin
              // RL8 mode zero holds scl from here
              st_q <= i2c_slv_pkg::S_AACK;
              stretch_q <= ~mode_q;
            end else begin
              // RL6 not ours, wait for start
              st_q <= i2c_slv_pkg::S_IDLE;
            end
          end
        end
        i2c_slv_pkg::S_AACK: begin
          if (lk.scl_fall) begin
            // RL1 mode one holds only after ack
            st_q <= i2c_slv_pkg::S_DATA;
            cnt_q <= 4'h0;
            sh_q <= tx_q;
            stretch_q <= mode_q;
          end
        end
        i2c_slv_pkg::S_DATA: begin
          if (e_transmit_collision_bit) begin
            // RL11 lost arbitration: release silently
            // RL12 back off until next start
            st_q <= i2c_slv_pkg::S_IDLE;
            stretch_q <= 1'b0;
          end else if (lk.scl_rise) begin
            cnt_q <= cnt_q + 4'h1;
            if (!dir_q) begin
              sh_q <= {sh_q[6:0], lk.sda};
            end
          end else if (byte_done) begin
            st_q <= i2c_slv_pkg::S_DACK;
          end else if (lk.scl_fall && dir_q) begin
            // next bit onto the wire
            sh_q <= {sh_q[6:0], 1'b1};
          end
        end
        i2c_slv_pkg::S_DACK: begin
          if (lk.scl_rise) begin
            nack_q <= lk.sda;
          end else if (lk.scl_fall) begin
            cnt_q <= 4'h0;
            if (dir_q && nack_q) begin
              // master ends its read
              st_q <= i2c_slv_pkg::S_IDLE;
            end else begin
              // RL3 data flag after ack sent
              st_q <= i2c_slv_pkg::S_DATA;
              stretch_q <= 1'b1;
              if (!dir_q) begin
                rx_q <= sh_q;
              end
            end
          end
        end
        default: begin
          st_q <= i2c_slv_pkg::S_IDLE;
        end
      endcase
    end
  end

  // open-drain drives: output level always low, enables pull
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  // RL8 no timeout on the hold
  assign SCL_OE = stretch_q & hold_busy;
  // ack low in address ack, on write data ack, and zero tx bits
  assign SDA_OE = (st_q == i2c_slv_pkg::S_AACK) |
    ((st_q == i2c_slv_pkg::S_DACK) & ~dir_q) |
    ((st_q == i2c_slv_pkg::S_DATA) & dir_q & ~sh_q[7] & (cnt_q != `BYTE_BITS));

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_mode1_after_ack: assert property ( // RL1
    (mode_q && $rose(flag_q[`FL_AHIT])) |-> $past(st_q) == i2c_slv_pkg::S_AACK)
    else $error("mode one address flag before ack");
  a_read_flags_join: assert property ( // RL2
    (mode_q && dir_q && $rose(flag_q[`FL_AHIT])) |-> flag_q[`FL_DRDY])
    else $error("read address flag without data flag");
  a_write_first_data: assert property ( // RL3
    (!dir_q && $rose(flag_q[`FL_DRDY])) |-> $past(st_q) == i2c_slv_pkg::S_DACK)
    else $error("write data flag before ack");
  a_idle_waits: assert property ( // RL5
    (st_q == i2c_slv_pkg::S_IDLE && !lk.start) |=> st_q == i2c_slv_pkg::S_IDLE)
    else $error("left idle without start");
  a_miss_ignored: assert property ( // RL6
    (st_q == i2c_slv_pkg::S_ADDR && byte_done && !addr_ok && !lk.start)
    |=> st_q == i2c_slv_pkg::S_IDLE && !$rose(flag_q[`FL_AHIT]))
    else $error("mismatch not ignored");
  a_hit_flags: assert property ( // RL7
    (en_q && st_q == i2c_slv_pkg::S_ADDR && byte_done && addr_ok && !mode_q)
    |=> flag_q[`FL_AHIT] && SCL_OE)
    else $error("match did not set flag");
  a_hold_no_timeout: assert property ( // RL8
    (SCL_OE && flag_q[`FL_AHIT] && !mode_q && !wr_acc) |=> SCL_OE)
    else $error("clock released while flag set");
  a_dir_stable: assert property ( // RL9
    !(st_q == i2c_slv_pkg::S_ADDR && byte_done && addr_ok) |=> $stable(dir_q))
    else $error("direction changed without address");
  a_transmit_collision_bit_release: assert property ( // RL10
    (e_transmit_collision_bit && en_q && !lk.stop && !lk.start)
    |=> transmit_collision_bit_q && !SDA_OE && !SCL_OE && st_q == i2c_slv_pkg::S_IDLE)
    else $error("collision not handled");
  a_transmit_collision_bit_silent: assert property ( // RL11
    e_transmit_collision_bit |=> flag_q == ($past(flag_q) & ~$past(fl_clr)))
    else $error("collision raised a flag");
  a_clear_releases: assert property ( // RL13
    (stretch_q && !hold_busy && en_q) |=> !stretch_q && !SCL_OE)
    else $error("clock not released after clear");

  c_read_match: cover property (mode_q && dir_q && $rose(flag_q[`FL_AHIT]));
  c_write_byte: cover property (!dir_q && $rose(flag_q[`FL_DRDY]));
  c_collision: cover property (e_transmit_collision_bit);
  c_mode0_hold: cover property (!mode_q && SCL_OE ##1 !SCL_OE);
endmodule
`default_nettype wire

// ---- i2c_master_model.sv ----
// behavioural i2c bus master for the slave address unit
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  // released lines float high through the pull-ups
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // four cycles; leaves the slave time to answer before the clock rises
  task automatic hp();
    repeat (4) @(posedge clk);
  endtask
  // data falls while the clock is high
  task automatic start();
    @(posedge clk) sda_low <= 1'b1;
    hp();
    scl_low <= 1'b1;
    hp();
  endtask
  // one bit; high phase waits while the slave stretches
  task automatic bitx(input logic b, output logic r);
    @(posedge clk) sda_low <= ~b;
    hp();
    scl_low <= 1'b0;
    @(posedge clk);
    while (scl !== 1'b1) @(posedge clk);
    // low five cycles, high three: one bit per 80 ns
    repeat (2) @(posedge clk);
    r = sda;
    scl_low <= 1'b1;
  endtask
  // eight bits, most significant first, readback ignored
  task automatic tx8(input logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(v[i], r);
    end
  endtask
  // data rises while the clock is high
  task automatic stop();
    @(posedge clk) sda_low <= 1'b1;
    hp();
    scl_low <= 1'b0;
    hp();
    sda_low <= 1'b0;
    hp();
  endtask
endmodule
`default_nettype wire

// ---- i2c_slave_addr_tb.sv ----
// self-checking bench of the i2c slave address unit
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slv_consts.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module i2c_slave_addr_tb;
  localparam logic [6:0] OWN_ADDR = 7'h5a; // slave address under test
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err, ack;
  logic scl_o, scl_oe, sda_o, sda_oe, irq, m_scl, m_sda;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  int bad_count, cmp_count, cycles;
  // open-drain wires, pulled high unless someone pulls low
  wire logic scl_w = ~(m_scl | (scl_oe & ~scl_o));
  wire logic sda_w = ~(m_sda | (sda_oe & ~sda_o));

  i2c_slave_addr dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda_w),
    .SDA_O(sda_o), .SDA_OE(sda_oe), .IRQ(irq));
  i2c_master_model m (.clk(clk), .scl(scl_w), .sda(sda_w), .scl_low(m_scl),
    .sda_low(m_sda));

  // 100 MHz system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, far above the fewer than one thousand cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  // one apb transfer; waits for pready, takes data at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd_data = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // slave stretch marks the end of an addressed phase
  task automatic wait_hold();
    while (scl_oe !== 1'b1) @(posedge clk);
  endtask

  // reset values and an unmapped place
  task automatic t_reset();
    apb(1'b0, `OFS_FLAGS, 32'h0);
    `CHK(rd_data, 32'h0)
    `CHK(irq, 1'b0)
    apb(1'b0, `OFS_STATUS, 32'h0);
    `CHK(rd_data, 32'h0)
    apb(1'b0, 12'h0fc, 32'h0);
    `CHK({err, rd_data}, {1'b1, 32'h0})
  endtask
  // mode zero write: clock held until the hit flag is cleared
  task automatic t_mode0_write();
    m.start();
    m.tx8({OWN_ADDR, 1'b0});
    wait_hold();
    apb(1'b0, `OFS_FLAGS, 32'h0);
    `CHK(rd_data[2:0], 3'h1)
    `CHK(irq, 1'b1)
    repeat (200) @(posedge clk);
    `CHK({scl_oe, scl_w}, 2'b10)
    apb(1'b0, `OFS_STATUS, 32'h0);
    `CHK(rd_data[0], 1'b0)
    apb(1'b1, `OFS_FLAGS, 32'h1);
    @(posedge clk);
    `CHK(scl_oe, 1'b0)
    m.bitx(1'b1, ack);
    `CHK(ack, 1'b0)
    m.stop();
    apb(1'b1, `OFS_FLAGS, 32'h7);
  endtask
  // mode one read, then a collision on the first data bit
  task automatic t_read_transmit_collision_bit();
    m.start();
    m.tx8({OWN_ADDR, 1'b1});
    m.bitx(1'b1, ack);
    `CHK(ack, 1'b0)
    wait_hold();
    apb(1'b0, `OFS_FLAGS, 32'h0);
    `CHK(rd_data[2:0], 3'h3)
    apb(1'b0, `OFS_STATUS, 32'h0);
    `CHK(rd_data[0], 1'b1)
    apb(1'b1, `OFS_DATA, 32'hc0);
    apb(1'b1, `OFS_FLAGS, 32'h3);
    // master pulls low over the slave's leading one
    m.tx8(8'h00);
    `CHK({sda_oe, scl_oe}, 2'b00)
    m.bitx(1'b1, ack);
    m.stop();
    apb(1'b0, `OFS_FLAGS, 32'h0);
    `CHK(rd_data[1:0], 2'h0)
    apb(1'b0, `OFS_STATUS, 32'h0);
    `CHK(rd_data[1], 1'b1)
    apb(1'b1, `OFS_STATUS, 32'h2);
    apb(1'b1, `OFS_FLAGS, 32'h7);
  endtask
  // foreign address: no ack, no hold, direction kept
  task automatic t_mismatch();
    m.start();
    m.tx8({OWN_ADDR ^ 7'h01, 1'b0});
    m.bitx(1'b1, ack);
    `CHK(ack, 1'b1)
    `CHK(scl_oe, 1'b0)
    m.stop();
    apb(1'b0, `OFS_FLAGS, 32'h0);
    `CHK(rd_data[2:0], 3'h0)
    apb(1'b0, `OFS_STATUS, 32'h0);
    `CHK(rd_data[0], 1'b1)
  endtask
  // mode one write: flags only after each acknowledge
  task automatic t_mode1_write();
    m.start();
    m.tx8({OWN_ADDR, 1'b0});
    m.bitx(1'b1, ack);
    `CHK({ack, irq}, 2'b00)
    wait_hold();
    apb(1'b0, `OFS_FLAGS, 32'h0);
    `CHK(rd_data[2:0], 3'h1)
    apb(1'b1, `OFS_MASK, 32'h0);
    // mask lands at the access edge; look once it has settled
    @(posedge clk);
    `CHK(irq, 1'b0)
    apb(1'b1, `OFS_MASK, 32'h7);
    @(posedge clk);
    `CHK(irq, 1'b1)
    apb(1'b1, `OFS_FLAGS, 32'h1);
    m.tx8(8'h3c);
    m.bitx(1'b1, ack);
    `CHK({ack, irq}, 2'b00)
    wait_hold();
    apb(1'b0, `OFS_FLAGS, 32'h0);
    `CHK(rd_data[2:0], 3'h2)
    apb(1'b0, `OFS_DATA, 32'h0);
    `CHK(rd_data[7:0], 8'h3c)
    apb(1'b1, `OFS_FLAGS, 32'h2);
    m.stop();
  endtask

  // counts, verdict, end of run
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    bad_count = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    apb(1'b1, `OFS_OWN, {25'h0, OWN_ADDR});
    apb(1'b1, `OFS_MASK, 32'h7);
    apb(1'b1, `OFS_CTRL, 32'h1);
    t_mode0_write();
    apb(1'b1, `OFS_CTRL, 32'h3);
    t_read_transmit_collision_bit();
    t_mismatch();
    t_mode1_write();
    complete_run();
  end
endmodule
`default_nettype wire
